/* flbrc_defs.svh */
// Constants for the linear burst read controller: field positions,
// reset value of the configuration word and the burst length codes.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef FLBRC_DEFS_SVH
`define FLBRC_DEFS_SVH

// ============================================================
// Configuration word layout
`define FLBRC_CFG_W 16
`define FLBRC_RM_BIT 15
`define FLBRC_RSV_BIT 14
`define FLBRC_LAT_HI 13
`define FLBRC_LAT_LO 10
`define FLBRC_HOLD_BIT 9
`define FLBRC_WC_BIT 8
`define FLBRC_BS_BIT 7
`define FLBRC_CC_BIT 6
`define FLBRC_BL_HI 2
`define FLBRC_BL_LO 0

// ============================================================
// Reset value and decode constants
`define FLBRC_CFG_RST 16'h9CC4
`define FLBRC_LAT_BASE 4'h2
`define FLBRC_BL_MIN 3'h1
`define FLBRC_BL_MAX 3'h4

// ============================================================
// Pin bus geometry
`define FLBRC_ADDR_W 20
`define FLBRC_DQ_W 32
`define FLBRC_BANK_BIT 19

`endif

/* flbrc_pkg.sv */
// Types shared by the burst read controller files.
// Assumes nothing beyond a SystemVerilog compiler.
package flbrc_pkg;

    // ============================================================
    // Burst sequencer states, one-hot
    typedef enum logic [2:0] {
        FLBRC_IDLE = 3'b001,
        FLBRC_LAT = 3'b010,
        FLBRC_DATA = 3'b100
    } flbrc_state_type;

endpackage : flbrc_pkg

/* flbrc_out_stage.sv */
// Output stage for the data bus and the end-of-burst indicator.
// Assumes its inputs are registered on the rising edge of core_clk.
`timescale 1ns/10ps
`default_nettype none

module flbrc_out_stage (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic rise_sel,
    input wire logic [31:0] dq_d,
    input wire logic dq_en_d,
    input wire logic ind_n_d,
    input wire logic ind_en_d,
    output logic [31:0] dq_o,
    output logic dq_oe_o,
    output logic ind_n_o,
    output logic ind_oe_o
);

    // Half-cycle delayed copy for falling-edge delivery
    logic [31:0] dq_f_q;
    logic dq_en_f_q;
    logic ind_n_f_q;
    logic ind_en_f_q;

    // ============================================================
    // Falling-edge copy; latency in clocks is unchanged, only the
    // moment the word appears moves half a period later
    always_ff @(negedge core_clk or negedge nrst) begin
        if (!nrst) begin
            dq_f_q <= 32'h0000_0000;
            dq_en_f_q <= 1'b0;
            ind_n_f_q <= 1'b1;
            ind_en_f_q <= 1'b0;
        end else begin
            dq_f_q <= dq_d;
            dq_en_f_q <= dq_en_d;
            ind_n_f_q <= ind_n_d;
            ind_en_f_q <= ind_en_d;
        end
    end

    // ============================================================
    // Edge select comes from the config word; a config write mid-burst
    // switches the mux while words are on the bus
    always_comb begin
        dq_o = rise_sel ? dq_d : dq_f_q;
        dq_oe_o = rise_sel ? dq_en_d : dq_en_f_q;
        ind_n_o = rise_sel ? ind_n_d : ind_n_f_q;
        ind_oe_o = rise_sel ? ind_en_d : ind_en_f_q;
    end

endmodule : flbrc_out_stage

`default_nettype wire

/* flbrc_core.sv */
// Linear burst read control as seen inside the flash device.
// Assumes host pins are synchronous to core_clk (the host burst clock)
// and that array_rdata answers array_addr_o in the same cycle.
`timescale 1ns/10ps
`default_nettype none

`include "flbrc_defs.svh"

// What this block does
// - Strobe low with chip enable starts burst
// - New strobe mid-burst drops old address
// - Reset stops burst and floats outputs
// - Reset restores default configuration word
// - Output enable high floats, sequencing continues
// - Indicator marks last address on bus
// - Indicator driven high until end pulse
// - Indicator low one clock, last or penultimate
// - Latency never affects asynchronous reads
// - Latency counted from start edge in clocks
// - Latency code plus two gives clocks
// - Falling edge keeps latency, data later
// - Each burst word held one clock
// - Config word reached only by commands
// - Config write ignored while engine busy
// - Config on low lanes, upper read zero
// - Config read latches bank for reads
// - Bit fifteen selects synchronous or asynchronous
// - Config word field layout
// - Clocking past last word wraps around
// - Burst length codes decode or disable
// - Chip enable high ends burst immediately
module flbrc_core (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic chip_en_n,
    input wire logic address_valid_strobe_n,
    input wire logic output_en_n,
    input wire logic wide_bus_sel,
    input wire logic [19:0] addr,
    input wire logic [31:0] array_rdata,
    input wire logic cmd_cfg_write,
    input wire logic cmd_cfg_read,
    input wire logic cmd_exit,
    input wire logic cmd_bank,
    input wire logic [31:0] cmd_wdata,
    input wire logic algo_busy,
    output logic [19:0] array_addr_o,
    output logic [31:0] dq_o,
    output logic dq_oe_o,
    output logic end_of_burst_indicator_n,
    output logic ind_oe_o,
    output logic [15:0] cfg_word_o
);
    import flbrc_pkg::*;

    // ============================================================
    // Declarations
    logic [15:0] cfg_q; // Configuration word
    logic cfg_rd_q; // Config read mode active
    logic cfg_bank_q; // Bank latched with config read
    flbrc_state_type state_q; // Burst sequencer state
    logic [3:0] lat_q; // Remaining latency clocks
    logic [4:0] beat_q; // Index of word now on the bus
    logic [4:0] mask_q; // Burst wrap mask, latched at start
    logic [19:0] addr_q; // Next array address
    logic [31:0] dq_q; // Data toward the output stage
    logic dq_en_q; // Data bus drive enable
    logic ind_n_q; // Indicator level
    logic ind_en_q; // Indicator drive enable
    logic burst_en; // Synchronous burst reads configured
    logic start; // Burst start this edge
    logic load; // A burst word is loaded this edge
    logic cfg_hit; // Current address hits the config bank
    logic [2:0] bl; // Burst length code
    logic [4:0] mask_d; // Wrap mask from length and bus width
    logic [4:0] beat_d; // Index of the word being loaded
    logic [4:0] ind_idx; // Beat at which the indicator fires
    logic [3:0] lat_n; // Latency in clocks
    logic [19:0] addr_nx; // Next word address inside the burst window
    // Every register above is written by exactly one process below; the
    // pins only ever see flop outputs, apart from the edge mux

    // ============================================================
    // Decode of configuration fields
    always_comb begin
        bl = cfg_q[`FLBRC_BL_HI:`FLBRC_BL_LO];
        // Codes 000, 101 to 111 leave asynchronous reads only
        burst_en = !cfg_q[`FLBRC_RM_BIT] && (bl >= `FLBRC_BL_MIN)
            && (bl <= `FLBRC_BL_MAX);
        // Codes with the top bit set are undefined; codes 14 and 15 wrap in four bits
        lat_n = cfg_q[`FLBRC_LAT_HI:`FLBRC_LAT_LO] + `FLBRC_LAT_BASE;
        // Beats: 8 bytes on x16 is 4 words, on x32 is 2 dwords
        case (bl)
            3'h1: mask_d = wide_bus_sel ? 5'h01 : 5'h03;
            3'h2: mask_d = wide_bus_sel ? 5'h03 : 5'h07;
            3'h3: mask_d = wide_bus_sel ? 5'h07 : 5'h0F;
            3'h4: mask_d = wide_bus_sel ? 5'h0F : 5'h1F;
            // A two-beat mask for undefined lengths is harmless: bursts are off
            default: mask_d = 5'h01;
        endcase
        cfg_hit = cfg_rd_q && (addr[`FLBRC_BANK_BIT] == cfg_bank_q);
        // Config reads stay single cycle even in burst mode
        start = !chip_en_n && !address_valid_strobe_n && burst_en && !cfg_hit;
        load = (state_q == FLBRC_DATA) || ((state_q == FLBRC_LAT) && (lat_q == 4'h1));
        beat_d = (state_q == FLBRC_LAT) ? 5'h00 : ((beat_q + 5'h01) & mask_q);
        // Penultimate beat when the timing bit is set
        ind_idx = mask_q - {4'h0, cfg_q[`FLBRC_WC_BIT]};
        // Low bits advance modulo burst size, high bits stay, so a host
        // that keeps clocking sees the burst again from its start word
        addr_nx = (addr_q & ~{15'h0000, mask_q}) |
            ({15'h0000, (addr_q[4:0] + 5'h01) & mask_q});
    end

    // ============================================================
    // Configuration word; only the command port reaches it
    // Reserved bits are stored as written; keeping them zero is for software
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_q <= `FLBRC_CFG_RST;
        end else if (cmd_cfg_write && !algo_busy) begin
            // Upper lanes are ignored on writes
            cfg_q <= cmd_wdata[15:0];
        end
    end

    // ============================================================
    // Config read mode: bank latched with the command
    // Entry wins over exit when both commands land in one cycle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_rd_q <= 1'b0;
            cfg_bank_q <= 1'b0;
        end else if (cmd_cfg_read) begin
            cfg_rd_q <= 1'b1;
            cfg_bank_q <= cmd_bank;
        end else if (cmd_exit) begin
            cfg_rd_q <= 1'b0;
        end
    end

    // ============================================================
    // Burst sequencer; output enable plays no part here, so a burst
    // keeps running while the pins float
    // A strobe held low restarts on every edge, so no word is ever sent
    // until the host lets it go high again
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= FLBRC_IDLE;
            lat_q <= 4'h0;
            mask_q <= 5'h01;
        end else if (chip_en_n) begin
            state_q <= FLBRC_IDLE;
        end else if (start) begin
            // A repeated strobe restarts; old address is dropped
            state_q <= FLBRC_LAT;
            lat_q <= lat_n;
            mask_q <= mask_d;
        end else begin
            case (state_q)
                FLBRC_IDLE: state_q <= FLBRC_IDLE;
                FLBRC_LAT: begin
                    lat_q <= lat_q - 4'h1;
                    if (lat_q == 4'h1) begin
                        state_q <= FLBRC_DATA;
                    end
                end
                // Words run on with wrap until chip enable or a new strobe
                FLBRC_DATA: state_q <= FLBRC_DATA;
                default: state_q <= FLBRC_IDLE;
            endcase
        end
    end

    // ============================================================
    // Beat index and array address with wrap inside the burst
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            beat_q <= 5'h00;
            addr_q <= 20'h0_0000;
        end else if (!chip_en_n && !address_valid_strobe_n) begin
            // Every strobe latches, so config reads work in burst mode too
            beat_q <= 5'h00;
            addr_q <= addr;
        end else if (load && !chip_en_n) begin
            beat_q <= beat_d;
            addr_q <= addr_nx;
        end
    end

    // ============================================================
    // Data and indicator toward the pins
    // Indicator enable follows output enable for the whole burst, latency
    // included, so the host sees it high before the end pulse
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            dq_q <= 32'h0000_0000;
            dq_en_q <= 1'b0;
            ind_n_q <= 1'b1;
            ind_en_q <= 1'b0;
        end else if (chip_en_n) begin
            dq_en_q <= 1'b0;
            ind_en_q <= 1'b0;
            ind_n_q <= 1'b1;
        end else if (state_q != FLBRC_IDLE && !start) begin
            if (load) begin
                dq_q <= array_rdata;
            end
            // Drive only on word beats, never during latency
            dq_en_q <= load && !output_en_n;
            ind_en_q <= !output_en_n;
            ind_n_q <= !(load && (beat_d == ind_idx));
        end else begin
            // Asynchronous or config read; latency unused here
            dq_q <= (cfg_rd_q && (addr_q[`FLBRC_BANK_BIT] == cfg_bank_q)) ?
                {16'h0000, cfg_q} : array_rdata;
            dq_en_q <= !output_en_n && !start;
            ind_en_q <= 1'b0;
            ind_n_q <= 1'b1;
        end
    end

    // ============================================================
    // Registered array address and config word copy to ports
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            array_addr_o <= 20'h0_0000;
            cfg_word_o <= `FLBRC_CFG_RST;
        end else begin
            // The array answers in the same cycle, so the address leads the
            // beat by one word; otherwise the first word would appear twice
            if (start) begin
                array_addr_o <= addr;
            end else if (load && !chip_en_n && address_valid_strobe_n) begin
                array_addr_o <= addr_nx;
            end else begin
                array_addr_o <= addr_q;
            end
            cfg_word_o <= cfg_q;
        end
    end

    // ============================================================
    // Output stage with delivery edge select
    // Falling delivery costs half a clock of output delay, not a clock count
    flbrc_out_stage u_out (
        .core_clk(core_clk),
        .nrst(nrst),
        .rise_sel(cfg_q[`FLBRC_CC_BIT]),
        .dq_d(dq_q),
        .dq_en_d(dq_en_q),
        .ind_n_d(ind_n_q),
        .ind_en_d(ind_en_q),
        .dq_o(dq_o),
        .dq_oe_o(dq_oe_o),
        .ind_n_o(end_of_burst_indicator_n),
        .ind_oe_o(ind_oe_o)
    );

    // ============================================================
    // Helper: clocks since the latest start
    // Saturates so it never wraps back into a plausible latency
    logic [4:0] since_q;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            since_q <= 5'h00;
        end else if (start) begin
            since_q <= 5'h01;
        end else if (since_q != 5'h1F) begin
            since_q <= since_q + 5'h01;
        end
    end

    // ============================================================
    // Checks
    // Checks mix registers with pins and decodes, sampled at each rising edge, so they see settled values
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_start_latch: assert property (start |=> state_q == FLBRC_LAT && lat_q == $past(lat_n))
        else $error("burst start did not load latency");
    a_first_data_lat: assert property (
        state_q == FLBRC_LAT && lat_q == 4'h1 && !start && !chip_en_n
        |-> since_q == {1'b0, lat_n})
        else $error("first data edge off latency");
    a_ce_ends: assert property (chip_en_n |=> state_q == FLBRC_IDLE && !dq_en_q && !ind_en_q)
        else $error("chip enable high did not end burst");
    a_ind_one_clk: assert property (!ind_n_q && mask_q != 5'h00 |=> ind_n_q)
        else $error("indicator low for more than one clock");
    a_ind_last_beat: assert property (
        !ind_n_q |-> beat_q == mask_q - {4'h0, cfg_q[`FLBRC_WC_BIT]})
        else $error("indicator on wrong beat");
    a_burst_wrap: assert property (
        state_q == FLBRC_DATA && beat_q == mask_q && !start && !chip_en_n |=> beat_q == 5'h00)
        else $error("burst did not wrap");
    a_cfg_busy_keep: assert property (cmd_cfg_write && algo_busy |=> $stable(cfg_q))
        else $error("config write taken while busy");
    a_oe_no_halt: assert property (
        state_q == FLBRC_LAT && lat_q == 4'h1 && !chip_en_n && !start
        |=> state_q == FLBRC_DATA)
        else $error("burst halted without chip enable");
    a_oe_floats: assert property (output_en_n |=> !dq_en_q)
        else $error("data driven with output enable high");
    a_async_no_burst: assert property (!burst_en |=> state_q == FLBRC_IDLE || $past(burst_en))
        else $error("burst entered in asynchronous mode");
    a_cfg_upper_zero: assert property (
        state_q == FLBRC_IDLE && cfg_rd_q && !chip_en_n
        && addr_q[`FLBRC_BANK_BIT] == cfg_bank_q |=> dq_q[31:16] == 16'h0000)
        else $error("config read upper lanes not zero");

    // Indicator drive, address, write and latch checks
    a_ind_driven: assert property (
        state_q == FLBRC_DATA && !output_en_n && !chip_en_n && !start |=> ind_en_q)
        else $error("indicator not driven with output enable low");
    a_cfg_write_lands: assert property (
        cmd_cfg_write && !algo_busy |=> cfg_q == $past(cmd_wdata[15:0]))
        else $error("config write not stored");
    a_addr_lead: assert property (
        state_q == FLBRC_DATA && !chip_en_n && address_valid_strobe_n |=> array_addr_o == addr_q)
        else $error("array address not one word ahead");
    a_restart_addr: assert property (
        start |=> addr_q == $past(addr) && beat_q == 5'h00)
        else $error("new strobe did not replace the address");
    a_async_latch: assert property (
        !burst_en && !chip_en_n && !address_valid_strobe_n |=> addr_q == $past(addr))
        else $error("asynchronous read did not latch address");

    // Covers: wrap, early indicator, restart, write, falling edge
    c_wrap: cover property (state_q == FLBRC_DATA && beat_q == mask_q ##1 beat_q == 5'h00);
    c_ind_early: cover property (!ind_n_q && cfg_q[`FLBRC_WC_BIT]);
    c_restart: cover property (state_q == FLBRC_DATA && start);
    c_cfg_write: cover property (cmd_cfg_write && !algo_busy);
    c_fall_edge: cover property (load && !cfg_q[`FLBRC_CC_BIT]);

endmodule : flbrc_core

`default_nettype wire

/* flbrc_host_model.sv */
// Host partner: drives the flash pins and answers array reads.
// Assumes every pin changes by non-blocking assignment after a rising edge.
`timescale 1ns/10ps
`default_nettype none

module flbrc_host_model (
    input wire logic core_clk,
    input wire logic [19:0] array_addr_o,
    output var logic chip_en_n,
    output var logic address_valid_strobe_n,
    output var logic output_en_n,
    output var logic wide_bus_sel,
    output var logic [19:0] addr,
    output logic [31:0] array_rdata,
    output var logic cmd_cfg_write,
    output var logic cmd_cfg_read,
    output var logic cmd_exit,
    output var logic cmd_bank,
    output var logic [31:0] cmd_wdata,
    output var logic algo_busy
);
    // ============================================================
    // Array model
    // Each word names its own address, so an order fault cannot hide
    assign array_rdata = {12'hA5A, array_addr_o};

    // Deselected, idle pins at time zero
    initial begin
        {chip_en_n, address_valid_strobe_n, output_en_n, wide_bus_sel} = 4'hE;
        {cmd_cfg_write, cmd_cfg_read, cmd_exit, cmd_bank, algo_busy} = 5'h00;
        addr = 20'h00000;
        cmd_wdata = 32'h00000000;
    end

    // ============================================================
    // Pin sequences
    // One-cycle strobe; the task returns at the edge that starts the burst
    task automatic start(input logic [19:0] a, input logic wide);
        @(posedge core_clk);
        chip_en_n <= 1'b0;
        address_valid_strobe_n <= 1'b0;
        output_en_n <= 1'b0;
        wide_bus_sel <= wide;
        addr <= a;
        @(posedge core_clk);
        address_valid_strobe_n <= 1'b1;
        // Address is only meaningful with the strobe; show garbage after
        addr <= ~a;
    endtask : start

    // Bursts run forever; only chip enable ends them here
    task automatic stop();
        @(posedge core_clk);
        chip_en_n <= 1'b1;
    endtask : stop

    task automatic set_oe(input logic v);
        @(posedge core_clk);
        output_en_n <= v;
    endtask : set_oe

    // Config write pulse; reserved bit 14 goes out as zero while the pulse is high
    task automatic cfg_wr(input logic busy, input logic [31:0] d);
        @(posedge core_clk);
        cmd_cfg_write <= 1'b1;
        cmd_wdata <= d & ~32'h00004000;
        algo_busy <= busy;
        @(posedge core_clk);
        cmd_cfg_write <= 1'b0;
        algo_busy <= 1'b0;
        cmd_wdata <= ~d;
    endtask : cfg_wr

    // Config read entry or exit pulse
    task automatic cmd(input logic rd, input logic ex, input logic bank);
        @(posedge core_clk);
        cmd_cfg_read <= rd;
        cmd_exit <= ex;
        cmd_bank <= bank;
        @(posedge core_clk);
        cmd_cfg_read <= 1'b0;
        cmd_exit <= 1'b0;
    endtask : cmd
endmodule : flbrc_host_model
`default_nettype wire

/* flbrc_bench.sv */
// Self-checking bench for the burst read controller: a table of bursts,
// then output enable, restart, reset, busy write and config read cases.
// Assumes the host partner drives every pin except clock and reset.
`timescale 1ns/10ps
`default_nettype none

module flbrc_bench;
    // ============================================================
    // Signals
    logic core_clk;
    logic nrst;
    logic chip_en_n, address_valid_strobe_n, output_en_n, wide_bus_sel;
    logic [19:0] addr, array_addr_o;
    logic [31:0] array_rdata, cmd_wdata, dq_o;
    logic cmd_cfg_write, cmd_cfg_read, cmd_exit, cmd_bank, algo_busy;
    logic dq_oe_o, end_of_burst_indicator_n, ind_oe_o;
    logic [15:0] cfg_word_o;
    logic [15:0] cw;
    int beats;
    int n_errors = 0;
    int checked = 0;

    // One burst: latency code, indicator timing, length code, width, start
    typedef struct packed {
        logic [3:0] lat;
        logic wc;
        logic [2:0] bl;
        logic wide;
        logic [19:0] a;
    } flbrc_row_type;
    // Aligned starts check the indicator; unaligned ones check the wrap
    flbrc_row_type rows [5] = '{'{4'h0, 1'b0, 3'h1, 1'b0, 20'h00040},
        '{4'h7, 1'b1, 3'h2, 1'b1, 20'h80020}, '{4'h1, 1'b0, 3'h3, 1'b1, 20'h00013},
        '{4'h3, 1'b1, 3'h4, 1'b0, 20'h00100}, '{4'h2, 1'b0, 3'h4, 1'b1, 20'h0003F}};

    flbrc_host_model flbrc_host_model_i (.core_clk, .array_addr_o, .chip_en_n,
        .address_valid_strobe_n, .output_en_n, .wide_bus_sel, .addr, .array_rdata,
        .cmd_cfg_write, .cmd_cfg_read, .cmd_exit, .cmd_bank, .cmd_wdata, .algo_busy);

    flbrc_core flbrc_core_i (.core_clk, .nrst, .chip_en_n, .address_valid_strobe_n,
        .output_en_n, .wide_bus_sel, .addr, .array_rdata, .cmd_cfg_write, .cmd_cfg_read,
        .cmd_exit, .cmd_bank, .cmd_wdata, .algo_busy, .array_addr_o, .dq_o, .dq_oe_o,
        .end_of_burst_indicator_n, .ind_oe_o, .cfg_word_o);

    // ============================================================
    // Checking and closing
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic summarize();
        if (n_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    // Waits lat edges after the start edge, then checks count beats in a row
    task automatic burst(input logic [19:0] a, input int n, input int lat, input logic wc,
                         input int count);
        logic [19:0] m;
        m = 20'(n - 1);
        repeat (lat) @(posedge core_clk);
        for (int k = 0; k < count; k++) begin
            #1;
            check("burst data", dq_o, {12'hA5A, (a & ~m) | ((a + 20'(k)) & m)});
            check("data enable", 32'(dq_oe_o), 32'h1);
            check("indicator drive", 32'(ind_oe_o), 32'h1);
            // Indicator position is only defined here for aligned starts
            if ((a & m) == 20'h0 && k < n) begin
                check("indicator", 32'(end_of_burst_indicator_n), 32'(k != n - 1 - wc));
            end
            @(posedge core_clk);
        end
    endtask : burst

    // ============================================================
    // Clock and watchdog
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // A hang counts as a mismatch
    initial begin
        #200000;
        n_errors++;
        summarize();
    end

    // ============================================================
    // Main sequence
    initial begin
        nrst = 1'b0;
        @(posedge core_clk);
        #1;
        check("reset config", 32'(cfg_word_o), 32'h9CC4);
        check("reset float", 32'({dq_oe_o, ind_oe_o}), 32'h0);
        @(posedge core_clk);
        nrst <= 1'b1;
        // Table of bursts; upper lanes carry junk that must be dropped
        foreach (rows[r]) begin
            cw = {2'b00, rows[r].lat, 1'b0, rows[r].wc, 2'b11, 3'b000, rows[r].bl};
            flbrc_host_model_i.cfg_wr(1'b0, {16'hC3A5, cw});
            repeat (2) @(posedge core_clk);
            #1;
            check("config word", 32'(cfg_word_o), 32'(cw));
            beats = (4 << rows[r].bl) / (rows[r].wide ? 4 : 2);
            flbrc_host_model_i.start(rows[r].a, rows[r].wide);
            burst(rows[r].a, beats, rows[r].lat + 2, rows[r].wc, beats + 1);
            flbrc_host_model_i.stop();
            repeat (2) @(posedge core_clk);
            #1;
            check("ce float", 32'({dq_oe_o, ind_oe_o}), 32'h0);
        end
        // Output enable high floats the bus, but the beats keep counting
        flbrc_host_model_i.start(20'h00200, 1'b1);
        burst(20'h00200, 16, 4, 1'b0, 2);
        flbrc_host_model_i.set_oe(1'b1);
        repeat (2) @(posedge core_clk);
        #1;
        check("oe float", 32'({dq_oe_o, ind_oe_o}), 32'h0);
        flbrc_host_model_i.set_oe(1'b0);
        repeat (2) @(posedge core_clk);
        #1;
        check("oe resume", dq_o, {12'hA5A, 20'h00208});
        // A new strobe mid-burst drops the old address
        flbrc_host_model_i.start(20'h00305, 1'b1);
        burst(20'h00305, 16, 4, 1'b0, 2);
        // Reset in mid-burst floats at once and restores the defaults
        nrst <= 1'b0;
        #1;
        check("reset burst", 32'({dq_oe_o, ind_oe_o}), 32'h0);
        check("reset default", 32'(cfg_word_o), 32'h9CC4);
        @(posedge core_clk);
        nrst <= 1'b1;
        flbrc_host_model_i.stop();
        // A write while the engine runs is dropped
        flbrc_host_model_i.cfg_wr(1'b1, 32'h00000001);
        repeat (2) @(posedge core_clk);
        #1;
        check("busy write", 32'(cfg_word_o), 32'h9CC4);
        // Config read in bank one; the other bank still reads the array
        flbrc_host_model_i.cmd(1'b1, 1'b0, 1'b1);
        flbrc_host_model_i.start(20'h80010, 1'b0);
        repeat (3) @(posedge core_clk);
        #1;
        check("config read", dq_o, 32'h00009CC4);
        flbrc_host_model_i.start(20'h00010, 1'b0);
        repeat (3) @(posedge core_clk);
        #1;
        check("other bank", dq_o, {12'hA5A, 20'h00010});
        flbrc_host_model_i.cmd(1'b0, 1'b1, 1'b0);
        flbrc_host_model_i.start(20'h80010, 1'b0);
        repeat (3) @(posedge core_clk);
        #1;
        check("after exit", dq_o, {12'hA5A, 20'h80010});
        // Falling-edge delivery: same latency, word shows half a clock later
        flbrc_host_model_i.cfg_wr(1'b0, 32'h00000081);
        flbrc_host_model_i.start(20'h00400, 1'b0);
        repeat (2) @(posedge core_clk);
        #1;
        check("fall early", 32'(dq_oe_o), 32'h0);
        #5;
        check("fall data", dq_o, {12'hA5A, 20'h00400});
        check("fall enable", 32'(dq_oe_o), 32'h1);
        summarize();
    end
endmodule : flbrc_bench
`default_nettype wire
